//--- ovr_consts.svh
/*
 * Codes, reset values, field positions and counts of the responder.
 * Assumes a 25 MHz core clock; included by its bare name.
 */
`ifndef OVR_CONSTS_SVH
`define OVR_CONSTS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define OVR_CMD_OPERATION    8'h01
`define OVR_CMD_CLEAR_FAULTS 8'h03
`define OVR_CMD_OV_RESPONSE  8'h41
`define OVR_CMD_UV_RESPONSE  8'h45
`define OVR_CMD_STATUS_BYTE  8'h78
`define OVR_CMD_STATUS_WORD  8'h79
`define OVR_CMD_STATUS_VOUT  8'h7A
`define OVR_CMD_RETRY_COUNT  8'hF7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OVR_OV_RESPONSE_RST  8'h80
`define OVR_UV_RESPONSE_RST  8'h7F
`define OVR_RETRY_COUNT_RST  3'h0
`define OVR_OPERATION_RST    1'b1

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OVR_ACT_MSB          7
`define OVR_ACT_LSB          6
`define OVR_RETRY_MSB        5
`define OVR_RETRY_LSB        3
`define OVR_DEGL_MSB         2
`define OVR_DEGL_LSB         0
`define OVR_OPERATION_ON_BIT 7
`define OVR_VOUT_OV_BIT      7
`define OVR_VOUT_UV_BIT      4
`define OVR_BYTE_VOUT_OV_BIT 5
`define OVR_BYTE_NONE_BIT    0
`define OVR_WORD_VOUT_BIT    7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OVR_CLK_PERIOD_NS    40
`define OVR_SAMPLE_PERIOD_NS 12200
`define OVR_SAMPLE_CYC       (`OVR_SAMPLE_PERIOD_NS / `OVR_CLK_PERIOD_NS)
`define OVR_RETRY_DELAY_MS   200
`define OVR_RETRY_CYC        (`OVR_RETRY_DELAY_MS * 1000000/`OVR_CLK_PERIOD_NS)
`define OVR_OFF_DELAY_CYC    250

`endif

//--- ovr_pkg.sv
/*
 * Types of the fault responder.
 * Assumes nothing.
 */
package ovr_pkg;

    typedef enum logic [1:0] {
        OVR_RSP_IDLE,
        OVR_RSP_DEGLITCH,
        OVR_RSP_GRACE,
        OVR_RSP_HELD
    } ovr_rsp_state_t;

    typedef enum logic [2:0] {
        OVR_CH_OFF,
        OVR_CH_ON,
        OVR_CH_SEQ_OFF,
        OVR_CH_RETRY_WAIT,
        OVR_CH_LATCHED
    } ovr_chan_state_t;

endpackage : ovr_pkg

//--- ovr_responder.sv
/*
 * One fault responder: deglitch and action for one comparator.
 * Assumes sample_tick_i pulses once per sample period.
 */
`timescale 1ns/10ps
`include "ovr_consts.svh"

module ovr_responder
    import ovr_pkg::*;
(
    input  wire logic       core_clk_i,    // Core clock.
    input  wire logic       resetn_i,      // Synchronous reset, active low.
    input  wire logic       fault_i,       // Comparator fault level.
    input  wire logic       sample_tick_i, // One pulse per sample period.
    input  wire logic       armed_i,       // Channel output is enabled.
    input  wire logic [7:0] cfg_i,         // Response configuration.
    output logic            event_o,       // Fault confirmed, one cycle.
    output logic            shutdown_o     // Shut channel off, one cycle.
);

    ovr_rsp_state_t state_q, state_d;
    logic [2:0]     cnt_q, cnt_d;
    logic [1:0]     action;
    logic [2:0]     deglitch;

    assign action   = cfg_i[`OVR_ACT_MSB:`OVR_ACT_LSB];
    assign deglitch = cfg_i[`OVR_DEGL_MSB:`OVR_DEGL_LSB];

    // ------------------------------------------------------------------
    // Deglitch and action sequencing
    // ------------------------------------------------------------------
    always_comb begin
        logic confirm;
        confirm    = 1'b0;
        state_d    = state_q;
        cnt_d      = cnt_q;
        event_o    = 1'b0;
        shutdown_o = 1'b0;
        case (state_q)
            OVR_RSP_IDLE: begin
                if (fault_i && armed_i) begin
                    cnt_d = 3'h0;
                    if (deglitch == 3'h0) begin
                        confirm = 1'b1;
                    end else begin
                        state_d = OVR_RSP_DEGLITCH;
                    end
                end
            end
            OVR_RSP_DEGLITCH: begin
                // A glitch shorter than the sample count is forgotten.
                if (!fault_i || !armed_i) begin
                    state_d = OVR_RSP_IDLE;
                end else if (sample_tick_i) begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q + 3'h1 == deglitch) begin
                        confirm = 1'b1;
                    end
                end
            end
            OVR_RSP_GRACE: begin
                if (!armed_i) begin
                    state_d = OVR_RSP_IDLE;
                end else if (sample_tick_i) begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q + 3'h1 >= deglitch) begin
                        shutdown_o = fault_i;
                        state_d    = OVR_RSP_HELD;
                    end
                end
            end
            OVR_RSP_HELD: begin
                if (!fault_i) begin
                    state_d = OVR_RSP_IDLE;
                end
            end
            default: state_d = OVR_RSP_IDLE;
        endcase
        if (confirm) begin
            event_o = 1'b1;
            cnt_d   = 3'h0;
            state_d = OVR_RSP_HELD;
            case (action)
                2'b00: shutdown_o = 1'b0;
                2'b01: begin
                    if (deglitch == 3'h0) begin
                        shutdown_o = 1'b1;
                    end else begin
                        state_d = OVR_RSP_GRACE;
                    end
                end
                default: shutdown_o = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state_q <= OVR_RSP_IDLE;
            cnt_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

endmodule : ovr_responder

//--- ovr_fault_responder.sv
/*
 * Overvoltage and undervoltage fault response of two channels:
 * commands, status, alert and channel enable.
 * Handles sequenced off, retry and latched off.
 * Assumes decoded commands on the command port and
 * comparators synchronous to core_clk_i.
 */
// Function
// - Faults set status byte, word and vout bits
// - Faults drive the active-low alert low
// - Action 00b keeps channel running
// - Action 01b waits deglitch-count samples first
// - Action 01b then shuts off if fault remains
// - Action 1xb shuts off with no grace
// - Shutdown follows the retry field policy
// - Retry 000b holds channel off, latched
// - Nonzero retry restarts up to global limit
// - Command off, bias loss, other fault stop retries; other fault not with track_en_i set
// - Retry field applies from next turn-on
// - Deglitch 000b acts at once
// - Nonzero deglitch ignores fault for N samples
// - Deglitch counts from first detection
// - Wait retry interval between restart attempts
// - Latched off cleared by control, operation, bias
// - Clear faults clears status, not latched off
`timescale 1ns/10ps
`include "ovr_consts.svh"

module ovr_fault_responder
    import ovr_pkg::*;
#(
    parameter int NUM_CH        = 2,
    parameter int SAMPLE_CYC    = `OVR_SAMPLE_CYC,
    parameter int RETRY_CYC     = `OVR_RETRY_CYC,
    parameter int OFF_DELAY_CYC = `OVR_OFF_DELAY_CYC
) (
    input  wire logic              core_clk_i,   // Core clock, 25 MHz.
    input  wire logic              resetn_i,     // Sync reset, active low.
    input  wire logic              cmd_valid_i,  // Command strobe.
    input  wire logic              cmd_write_i,  // 1 write, 0 read.
    input  wire logic [7:0]        cmd_code_i,   // Command code.
    input  wire logic              cmd_page_i,   // Channel page.
    input  wire logic [7:0]        cmd_wdata_i,  // Write data byte.
    output logic      [7:0]        cmd_rdata_o,  // Read data byte.
    output logic                   cmd_rvalid_o, // Read data valid.
    input  wire logic [NUM_CH-1:0] control_i,    // Control pin level.
    input  wire logic              bias_ok_i,    // Bias power present.
    input  wire logic [NUM_CH-1:0] track_en_i,   // Sequenced off select.
    input  wire logic [NUM_CH-1:0] ov_cmp_i,     // Overvoltage comparator.
    input  wire logic [NUM_CH-1:0] uv_cmp_i,     // Undervoltage comparator.
    output logic      [NUM_CH-1:0] chan_en_o,    // Channel enable.
    output logic                   host_alert_n_o // Alert, active low.
);

    localparam int CW = $clog2(RETRY_CYC + OFF_DELAY_CYC + 1) + 1;
    localparam int SW = $clog2(SAMPLE_CYC + 1);

    // ------------------------------------------------------------------
    // Sample period time base
    // ------------------------------------------------------------------
    logic [SW-1:0] tick_cnt_q, tick_cnt_d;
    logic          tick;

    always_comb begin
        tick       = (tick_cnt_q == SW'(SAMPLE_CYC - 1));
        tick_cnt_d = tick ? '0 : tick_cnt_q + SW'(1);
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers and command port
    // ------------------------------------------------------------------
    logic [7:0] ov_cfg_q [NUM_CH];
    logic [7:0] ov_cfg_d [NUM_CH];
    logic [7:0] uv_cfg_q [NUM_CH];
    logic [7:0] uv_cfg_d [NUM_CH];
    logic [NUM_CH-1:0] op_on_q, op_on_d;
    logic [2:0]        retry_limit_q, retry_limit_d;
    logic [7:0]        rdata_d;
    logic              rvalid_d;
    logic              clear_faults;
    logic [NUM_CH-1:0] st_ov_q, st_ov_d, st_uv_q, st_uv_d;
    logic [NUM_CH-1:0] ev_ov, ev_uv;
    logic [7:0]        vout_sel;
    logic              pg;
    logic              wr;

    assign wr           = cmd_valid_i && cmd_write_i;
    assign clear_faults = wr && (cmd_code_i == `OVR_CMD_CLEAR_FAULTS);
    assign pg           = cmd_page_i;

    always_comb begin
        vout_sel = 8'h00;
        vout_sel[`OVR_VOUT_OV_BIT] = st_ov_q[pg];
        vout_sel[`OVR_VOUT_UV_BIT] = st_uv_q[pg];
    end

    always_comb begin
        op_on_d       = op_on_q;
        retry_limit_d = retry_limit_q;
        for (int c = 0; c < NUM_CH; c++) begin
            ov_cfg_d[c] = ov_cfg_q[c];
            uv_cfg_d[c] = uv_cfg_q[c];
        end
        if (wr) begin
            case (cmd_code_i)
                `OVR_CMD_OPERATION:
                    op_on_d[pg] = cmd_wdata_i[`OVR_OPERATION_ON_BIT];
                `OVR_CMD_OV_RESPONSE: ov_cfg_d[pg] = cmd_wdata_i;
                `OVR_CMD_UV_RESPONSE: uv_cfg_d[pg] = cmd_wdata_i;
                `OVR_CMD_RETRY_COUNT: retry_limit_d = cmd_wdata_i[2:0];
                default: ;
            endcase
        end
        // Unknown codes read as zero rather than holding stale data.
        rvalid_d = cmd_valid_i && !cmd_write_i;
        rdata_d  = 8'h00;
        if (rvalid_d) begin
            case (cmd_code_i)
                `OVR_CMD_OPERATION:
                    rdata_d = {op_on_q[pg], 7'h00};
                `OVR_CMD_OV_RESPONSE: rdata_d = ov_cfg_q[pg];
                `OVR_CMD_UV_RESPONSE: rdata_d = uv_cfg_q[pg];
                `OVR_CMD_RETRY_COUNT: rdata_d = {5'h00, retry_limit_q};
                `OVR_CMD_STATUS_VOUT: rdata_d = vout_sel;
                `OVR_CMD_STATUS_BYTE,
                `OVR_CMD_STATUS_WORD: begin
                    rdata_d[`OVR_BYTE_VOUT_OV_BIT] = st_ov_q[pg];
                    rdata_d[`OVR_BYTE_NONE_BIT]    = st_uv_q[pg];
                end
                8'h7F: rdata_d[`OVR_WORD_VOUT_BIT] = |vout_sel;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            op_on_q       <= {NUM_CH{`OVR_OPERATION_RST}};
            retry_limit_q <= `OVR_RETRY_COUNT_RST;
            cmd_rdata_o   <= 8'h00;
            cmd_rvalid_o  <= 1'b0;
            for (int c = 0; c < NUM_CH; c++) begin
                ov_cfg_q[c] <= `OVR_OV_RESPONSE_RST;
                uv_cfg_q[c] <= `OVR_UV_RESPONSE_RST;
            end
        end else begin
            op_on_q       <= op_on_d;
            retry_limit_q <= retry_limit_d;
            cmd_rdata_o   <= rdata_d;
            cmd_rvalid_o  <= rvalid_d;
            for (int c = 0; c < NUM_CH; c++) begin
                ov_cfg_q[c] <= ov_cfg_d[c];
                uv_cfg_q[c] <= uv_cfg_d[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status bits and alert
    // ------------------------------------------------------------------
    // A fault confirmed in the same cycle as a clear still sets its bit.
    always_comb begin
        st_ov_d = (clear_faults ? '0 : st_ov_q) | ev_ov;
        st_uv_d = (clear_faults ? '0 : st_uv_q) | ev_uv;
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_ov_q        <= '0;
            st_uv_q        <= '0;
            host_alert_n_o <= 1'b1;
        end else begin
            st_ov_q        <= st_ov_d;
            st_uv_q        <= st_uv_d;
            host_alert_n_o <= ~(|st_ov_d || |st_uv_d);
        end
    end

    // ------------------------------------------------------------------
    // Per-channel responders and enable sequencing
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        ovr_chan_state_t st_q, st_d;
        logic [CW-1:0]   cnt_q, cnt_d;
        logic [2:0]      tries_q, tries_d;
        logic            ov_retry_q, ov_retry_d;
        logic            uv_retry_q, uv_retry_d;
        logic            cause_ov_q, cause_ov_d;
        logic            en_q, en_d;
        logic            sd_ov, sd_uv;
        logic            cmd_on, armed, shut_ov;

        assign cmd_on = control_i[ch] && op_on_q[ch] && bias_ok_i;
        assign armed  = (st_q == OVR_CH_ON) || (st_q == OVR_CH_SEQ_OFF);

        ovr_responder u_ov (
            .core_clk_i    (core_clk_i),
            .resetn_i      (resetn_i),
            .fault_i       (ov_cmp_i[ch]),
            .sample_tick_i (tick),
            .armed_i       (armed),
            .cfg_i         (ov_cfg_q[ch]),
            .event_o       (ev_ov[ch]),
            .shutdown_o    (sd_ov)
        );

        ovr_responder u_uv (
            .core_clk_i    (core_clk_i),
            .resetn_i      (resetn_i),
            .fault_i       (uv_cmp_i[ch]),
            .sample_tick_i (tick),
            .armed_i       (armed),
            .cfg_i         (uv_cfg_q[ch]),
            .event_o       (ev_uv[ch]),
            .shutdown_o    (sd_uv)
        );

        always_comb begin
            logic retry_ok;
            logic fire;
            st_d       = st_q;
            cnt_d      = cnt_q;
            tries_d    = tries_q;
            ov_retry_d = ov_retry_q;
            uv_retry_d = uv_retry_q;
            cause_ov_d = cause_ov_q;
            fire       = 1'b0;
            shut_ov    = sd_ov;
            retry_ok   = 1'b0;
            case (st_q)
                OVR_CH_OFF: begin
                    if (cmd_on) begin
                        st_d    = OVR_CH_ON;
                        tries_d = 3'h0;
                        // Retry policy is sampled only at turn-on.
                        ov_retry_d = |ov_cfg_q[ch]
                            [`OVR_RETRY_MSB:`OVR_RETRY_LSB];
                        uv_retry_d = |uv_cfg_q[ch]
                            [`OVR_RETRY_MSB:`OVR_RETRY_LSB];
                    end
                end
                OVR_CH_ON: begin
                    if (!cmd_on) begin
                        st_d = OVR_CH_OFF;
                    end else if (sd_ov || sd_uv) begin
                        cnt_d = '0;
                        if (track_en_i[ch]) begin
                            st_d       = OVR_CH_SEQ_OFF;
                            cause_ov_d = shut_ov;
                        end else begin
                            fire = 1'b1;
                        end
                    end
                end
                OVR_CH_SEQ_OFF: begin
                    shut_ov = cause_ov_q;
                    cnt_d   = cnt_q + CW'(1);
                    if (!cmd_on) begin
                        st_d = OVR_CH_OFF;
                    end else if (cnt_q == CW'(OFF_DELAY_CYC - 1)) begin
                        fire  = 1'b1;
                        cnt_d = '0;
                    end
                end
                OVR_CH_RETRY_WAIT: begin
                    cnt_d = cnt_q + CW'(1);
                    if (!cmd_on) begin
                        st_d = OVR_CH_OFF;
                    end else if (cnt_q == CW'(RETRY_CYC - 1)) begin
                        st_d    = OVR_CH_ON;
                        tries_d = tries_q + 3'h1;
                    end
                end
                OVR_CH_LATCHED: begin
                    if (!cmd_on) begin
                        st_d = OVR_CH_OFF;
                    end
                end
                default: st_d = OVR_CH_OFF;
            endcase
            if (fire) begin
                retry_ok = (shut_ov ? ov_retry_q : uv_retry_q)
                        && (tries_q < retry_limit_q)
                        && (tries_q == '0 || shut_ov == cause_ov_q);
                cause_ov_d = shut_ov;
                cnt_d      = '0;
                st_d = retry_ok ? OVR_CH_RETRY_WAIT
                                : OVR_CH_LATCHED;
            end
            en_d = (st_d == OVR_CH_ON) || (st_d == OVR_CH_SEQ_OFF);
        end

        always_ff @(posedge core_clk_i) begin
            if (!resetn_i) begin
                st_q       <= OVR_CH_OFF;
                cnt_q      <= '0;
                tries_q    <= 3'h0;
                ov_retry_q <= 1'b0;
                uv_retry_q <= 1'b0;
                cause_ov_q <= 1'b0;
                en_q       <= 1'b0;
            end else begin
                st_q       <= st_d;
                cnt_q      <= cnt_d;
                tries_q    <= tries_d;
                ov_retry_q <= ov_retry_d;
                uv_retry_q <= uv_retry_d;
                cause_ov_q <= cause_ov_d;
                en_q       <= en_d;
            end
        end

        assign chan_en_o[ch] = en_q;
    end

endmodule : ovr_fault_responder

//--- ovr_supply_model.sv
/* Supply model: output comparators of two channels.
   Assumes fault requests from the bench. */
`timescale 1ns/10ps
module ovr_supply_model (
    input  wire logic [1:0] chan_en_i, // Channel enables.
    input  wire logic [1:0] ov_req_i,  // Forced overvoltage.
    input  wire logic [1:0] uv_req_i,  // Forced undervoltage.
    output logic      [1:0] ov_cmp_o,  // Overvoltage comparator.
    output logic      [1:0] uv_cmp_o   // Undervoltage comparator.
);
    // A disabled output cannot sit above its limit.
    assign ov_cmp_o = ov_req_i & chan_en_i;
    assign uv_cmp_o = uv_req_i;
endmodule : ovr_supply_model

//--- ovr_fault_responder_sva.sv
/* Port checker of the fault responder, channel 0 view.
   Assumes the bench never writes OPERATION on page 0. */
`timescale 1ns/10ps
module ovr_checker_sva
    import ovr_pkg::*;
#(
    parameter int NUM_CH        = 2
) (
    input wire logic              core_clk_i,     // Clock.
    input wire logic              resetn_i,       // Reset.
    input wire logic              cmd_valid_i,    // Strobe.
    input wire logic              cmd_write_i,    // Write.
    input wire logic [7:0]        cmd_code_i,     // Code.
    input wire logic              cmd_page_i,     // Page.
    input wire logic [7:0]        cmd_wdata_i,    // Write byte.
    input wire logic [7:0]        cmd_rdata_o,    // Read byte.
    input wire logic              cmd_rvalid_o,   // Read valid.
    input wire logic [NUM_CH-1:0] control_i,      // Control pins.
    input wire logic              bias_ok_i,      // Bias.
    input wire logic [NUM_CH-1:0] track_en_i,     // Sequenced off.
    input wire logic [NUM_CH-1:0] ov_cmp_i,       // OV comparators.
    input wire logic [NUM_CH-1:0] uv_cmp_i,       // UV comparators.
    input wire logic [NUM_CH-1:0] chan_en_o,      // Enables.
    input wire logic              host_alert_n_o  // Alert.
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] cfg_q;
    wire        clr_w = cmd_valid_i && cmd_write_i && cmd_code_i == 8'h03;
    // A private copy of the page 0 overvoltage configuration.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg_q <= 8'h80;
        end else if (cmd_valid_i && cmd_write_i && !cmd_page_i
                     && cmd_code_i == 8'h41) begin
            cfg_q <= cmd_wdata_i;
        end
    end
    sequence s_read;
        cmd_valid_i && !cmd_write_i;
    endsequence
    sequence s_new_ov;
        $rose(ov_cmp_i[0]) && chan_en_o[0] && $past(chan_en_o[0]);
    endsequence
    AST_RVALID: assert property (s_read |=> cmd_rvalid_o)
        else $error("no rvalid");
    AST_RVALID_CAUSE: assert property (cmd_rvalid_o
        |-> $past(cmd_valid_i && !cmd_write_i)) else $error("stray rvalid");
    AST_RDATA_IDLE: assert property (!cmd_rvalid_o |-> cmd_rdata_o == 8'h00)
        else $error("rdata not zero");
    AST_ALERT_FAST: assert property (s_new_ov ##0 cfg_q[2:0] == 3'h0
        |=> !host_alert_n_o) else $error("alert late");
    AST_SHUT_FAST: assert property (s_new_ov ##0 (cfg_q[7]
        && cfg_q[2:0] == 3'h0 && !track_en_i[0]) |-> ##2 !chan_en_o[0])
        else $error("not shut off");
    AST_ACT_RUN: assert property (chan_en_o[0] && cfg_q[7:6] == 2'b00
        && !uv_cmp_i[0] && control_i[0] && bias_ok_i |=> chan_en_o[0])
        else $error("channel stopped");
    AST_DEGL_HOLD: assert property (s_new_ov ##0 (host_alert_n_o
        && cfg_q[2:0] >= 3'h2) |=> host_alert_n_o [*3])
        else $error("acted too soon");
    AST_ON_CAUSE: assert property ($rose(chan_en_o[0])
        |-> $past(control_i[0] && bias_ok_i)) else $error("turned on alone");
    AST_ALERT_CLR: assert property ($rose(host_alert_n_o)
        |-> $past(clr_w, 1) || $past(clr_w, 2)) else $error("alert released");
endmodule : ovr_checker_sva
bind ovr_fault_responder ovr_checker_sva #(.NUM_CH(NUM_CH)) u_sva (.*);

//--- testbench.sv
/* Self-checking bench of the fault responder and supply model.
   Assumes shortened counts. */
`timescale 1ns/10ps
module testbench;
    localparam int SC = 4, RC = 50, OC = 10;
    logic clk = 1'b0, rst_n, cv, cw, cp, rv, bias, alert_n;
    logic [7:0] cc, cd, rd;
    logic [1:0] ctl, trk, ovq, uvq, ov, uv, en;
    int fail_count = 0, num_checks = 0, seed, i, run, rises, mn_on, mn_off;
    logic prev;
    always #20 clk = ~clk;
    ovr_supply_model u_sup (.chan_en_i(en), .ov_req_i(ovq), .uv_req_i(uvq),
        .ov_cmp_o(ov), .uv_cmp_o(uv));
    ovr_fault_responder #(.NUM_CH(2), .SAMPLE_CYC(SC), .RETRY_CYC(RC),
        .OFF_DELAY_CYC(OC)) u_dut (.core_clk_i(clk), .resetn_i(rst_n),
        .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_code_i(cc), .cmd_page_i(cp),
        .cmd_wdata_i(cd), .cmd_rdata_o(rd), .cmd_rvalid_o(rv),
        .control_i(ctl), .bias_ok_i(bias), .track_en_i(trk), .ov_cmp_i(ov),
        .uv_cmp_i(uv), .chan_en_o(en), .host_alert_n_o(alert_n));
    function automatic logic [7:0] vout_exp(input logic o, u);
        return {o, 2'b00, u, 4'h0};
    endfunction : vout_exp
    function automatic logic [7:0] byte_exp(input logic o, u);
        return {2'b00, o, 4'h0, u};
    endfunction : byte_exp
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
        end
    endtask : tick
    task automatic cmd(input logic w, input logic [7:0] c, input logic p,
                       logic [7:0] d);
        {cv, cw, cc, cp, cd} = {1'b1, w, c, p, d};
        @(posedge clk);
        cv <= 1'b0;
        #1;
    endtask : cmd
    task automatic rdc(input string nm, input logic [7:0] c, input logic p,
                       input logic [7:0] e);
        cmd(1'b0, c, p, 8'h00);
        chk(nm, e, rd);
        chk("rvalid", 8'h01, {7'h0, rv});
    endtask : rdc
    task automatic wait_en(input int ch, input logic e, input int k);
        for (int j = 0; j < k && en[ch] !== e; j++) tick(1);
        chk("chan_en", {7'h0, e}, {7'h0, en[ch]});
        if (en[ch] !== e) stop_test();
    endtask : wait_en
    task automatic relatch(input int ch);
        ctl[ch] = 1'b0;
        tick(2);
        ctl[ch] = 1'b1;
        wait_en(ch, 1'b1, 5);
        cmd(1'b1, 8'h03, 1'b0, 8'h00);
        tick(2);
    endtask : relatch
    initial begin
        seed = 11;
        {rst_n, cv, cw, cc, cp, cd, trk, ovq, uvq} = '0;
        {ctl, bias} = 3'b111;
        tick(4);
        rst_n = 1'b1;
        rdc("ov_cfg", 8'h41, 1'b0, 8'h80);
        rdc("uv_cfg", 8'h45, 1'b1, 8'h7F);
        rdc("retry_limit", 8'hF7, 1'b0, 8'h00);
        rdc("unmapped", 8'hEE, 1'b0, 8'h00);
        wait_en(0, 1'b1, 5);
        wait_en(1, 1'b1, 5);
        cmd(1'b1, 8'h41, 1'b0, 8'h00);
        ovq[0] = 1'b1;
        tick(5 + ($unsigned($random(seed)) % 16));
        chk("chan_en0", 8'h01, {7'h0, en[0]});
        chk("alert_n", 8'h00, {7'h0, alert_n});
        rdc("status_vout", 8'h7A, 1'b0, vout_exp(1'b1, 1'b0));
        rdc("status_byte", 8'h78, 1'b0, byte_exp(1'b1, 1'b0));
        rdc("status_word", 8'h79, 1'b0, byte_exp(1'b1, 1'b0));
        rdc("vout_sum", 8'h7F, 1'b0, 8'h80);
        ovq[0] = 1'b0;
        cmd(1'b1, 8'h45, 1'b1, 8'h00);
        uvq[1] = 1'b1;
        tick(3);
        rdc("status_vout1", 8'h7A, 1'b1, vout_exp(1'b0, 1'b1));
        uvq[1] = 1'b0;
        cmd(1'b1, 8'h03, 1'b0, 8'h00);
        tick(2);
        chk("alert_n", 8'h01, {7'h0, alert_n});
        rdc("status_clear", 8'h7A, 1'b0, 8'h00);
        cmd(1'b1, 8'h41, 1'b0, 8'h80);
        ovq[0] = 1'b1;
        wait_en(0, 1'b0, 6);
        chk("chan_en1", 8'h01, {7'h0, en[1]});
        ovq[0] = 1'b0;
        cmd(1'b1, 8'h03, 1'b0, 8'h00);
        tick(RC + 10);
        chk("latched", 8'h00, {7'h0, en[0]});
        relatch(0);
        cmd(1'b1, 8'h41, 1'b0, 8'hC3);
        ovq[0] = 1'b1;
        tick(1 + ($unsigned($random(seed)) % (2 * SC)));
        ovq[0] = 1'b0;
        tick(2);
        chk("glitch", 8'h01, {7'h0, alert_n});
        ovq[0] = 1'b1;
        wait_en(0, 1'b0, 3 * SC + 5);
        ovq[0] = 1'b0;
        relatch(0);
        cmd(1'b1, 8'h41, 1'b0, 8'h41);
        ovq[0] = 1'b1;
        for (i = 0; i < 3 * SC && alert_n !== 1'b0; i++) tick(1);
        ovq[0] = 1'b0;
        tick(3 * SC);
        chk("grace_run", 8'h01, {7'h0, en[0]});
        cmd(1'b1, 8'h03, 1'b0, 8'h00);
        ovq[0] = 1'b1;
        wait_en(0, 1'b0, 4 * SC + 4);
        ovq[0] = 1'b0;
        relatch(0);
        cmd(1'b1, 8'hF7, 1'b0, 8'h02);
        cmd(1'b1, 8'h41, 1'b1, 8'h88);
        trk[1] = 1'b1;
        relatch(1);
        ovq[1] = 1'b1;
        {rises, run, mn_on, mn_off} = {32'd0, 32'd0, 32'd999, 32'd999};
        for (i = 0; i < 600; i++) begin
            prev = en[1];
            tick(1);
            run++;
            if (en[1] !== prev) begin
                if (prev && run < mn_on) mn_on = run;
                if (!prev && run < mn_off) mn_off = run;
                rises += int'(en[1]);
                run = 0;
            end
        end
        chk("restarts", 8'h02, 8'(rises));
        chk("retry_gap", 8'h01, 8'(mn_off >= RC));
        chk("seq_off", 8'h01, 8'(mn_on >= OC));
        chk("gave_up", 8'h00, {7'h0, en[1]});
        {ovq[1], trk[1]} = 2'b00;
        relatch(1);
        bias = 1'b0;
        wait_en(0, 1'b0, 20);
        wait_en(1, 1'b0, 20);
        bias = 1'b1;
        wait_en(0, 1'b1, 5);
        wait_en(1, 1'b1, 5);
        cmd(1'b1, 8'h01, 1'b1, 8'h00);
        wait_en(1, 1'b0, 5);
        stop_test();
    end
endmodule : testbench
